// *** gfs_consts.svh ***
// Timing constants and code values for the gating fault supervisor
`ifndef GFS_CONSTS_SVH
`define GFS_CONSTS_SVH
`define GFS_CLK_HZ          40000000
`define GFS_END_HOLD_S      20
`define GFS_MIN_HOLD_S      4
`define GFS_FIELD_WAIT_S    4
`define GFS_FIELD_WAIT4_S   2
`define GFS_IDLE_TIMEOUT_S  3600
`define GFS_TEACH_KEY_S     4
`define GFS_TEACH_TIMEOUT_S 150
`define GFS_SKEW_MS         500
`define GFS_RESP_LIMIT_MS   99
`define GFS_MS_CYCLES       (`GFS_CLK_HZ / 1000)
`define GFS_MODE_1          3'h1
`define GFS_MODE_4          3'h4
`define GFS_MODE_5          3'h5
`define GFS_MODE_6          3'h6
`define GFS_FAULT_NONE      8'h00
`define GFS_FAULT_END_HOLD  8'h01
`define GFS_FAULT_MIN_HOLD  8'h02
`define GFS_FAULT_NO_FIELD  8'h03
`define GFS_FAULT_ANTIVAL   8'h04
`define GFS_FAULT_MODE      8'h05
`define GFS_FAULT_CHANNEL   8'h06
`define GFS_FAULT_SKEW      8'h07
`define GFS_FAULT_TOP_BEAM  8'h08
`define GFS_WARN_NONE       8'h00
`define GFS_WARN_LATE_FIELD 8'h11
`define GFS_WARN_IDLE_OFF   8'h12
`define GFS_WARN_TEACH_KEY  8'h13
`define GFS_WARN_TEACH_TIME 8'h14
`define GFS_WARN_RESP_TIME  8'h15
`define GFS_WARN_TEACH_BAD  8'h16
`define GFS_WARN_TEACH_DATA 8'h17
`define GFS_WARN_CROSS      8'h18
`define GFS_WARN_START_CS   8'h19
`define GFS_WARN_ACK_REFUSE 8'h1a
`define GFS_WARN_FIELD_FREE 8'h1b
`define GFS_WARN_CS_DROP    8'h1c
`endif

// *** gfs_pkg.sv ***
// Types for the gating fault supervisor
package gfs_pkg;
    typedef enum logic [2:0] {
        GFS_ST_START   = 3'b000,
        GFS_ST_OFF     = 3'b001,
        GFS_ST_ON      = 3'b010,
        GFS_ST_GATING  = 3'b011,
        GFS_ST_POST    = 3'b100,
        GFS_ST_LOCKED  = 3'b101
    } gfs_state_e;
endpackage

// *** gfs_supervisor.sv ***
// Gating fault supervisor: sequence timing, teach checks and safety output control
`timescale 1ns/1ps
`include "gfs_consts.svh"

// Summary of operation
// - Control held 20 s after sequence: fault
// - Mode 5 control released before 4 s: fault
// - No field break within 1 h: fault
// - Modes 1/6 non-antivalent at start: outputs off
// - Bad or changed mode locks device
// - Channel error reported, then automatic reset
// - Late field break: warning, wait restart
// - Control dropped, 1 h expires: off, warning
// - Teach key skew over 4 s: warning
// - Teach over 2.5 min aborted: warning
// - Blanking response over 99 ms: warning
// - Incomplete teach keeps outputs off, warning
// - Implausible teach data keeps outputs off
// - Restart toggling with other line: warning
// - Control active at start-up: display warning
// - Acknowledge refused on wrong control levels
// - Field free too long: off, warning
// - Control drop without break: warning, on
// - Mode 6 top beam break: off
// - Modes 1/6 hold/control skew over 0.5 s: off
module gfs_supervisor #(
    parameter int unsigned MS_CYCLES       = `GFS_MS_CYCLES,
    parameter int unsigned END_HOLD_MS     = `GFS_END_HOLD_S * 1000,
    parameter int unsigned MIN_HOLD_MS     = `GFS_MIN_HOLD_S * 1000,
    parameter int unsigned FIELD_WAIT_MS   = `GFS_FIELD_WAIT_S * 1000,
    parameter int unsigned FIELD_WAIT4_MS  = `GFS_FIELD_WAIT4_S * 1000,
    parameter int unsigned IDLE_TIMEOUT_MS = `GFS_IDLE_TIMEOUT_S * 1000,
    parameter int unsigned TEACH_KEY_MS    = `GFS_TEACH_KEY_S * 1000,
    parameter int unsigned TEACH_TIME_MS   = `GFS_TEACH_TIMEOUT_S * 1000,
    parameter int unsigned SKEW_MS         = `GFS_SKEW_MS,
    parameter int unsigned FREE_LIMIT_MS   = 60000
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [2:0]  i_mode,
    input  wire logic        i_mode_valid,
    input  wire logic        i_gating_control,
    input  wire logic        i_transport_hold_input,
    input  wire logic        i_restart_button_input,
    input  wire logic        i_field_interrupted,
    input  wire logic        i_top_beams_interrupted,
    input  wire logic        i_sequence_end,
    input  wire logic        i_channel_error,
    input  wire logic        i_teach_active,
    input  wire logic        i_teach_key_a,
    input  wire logic        i_teach_key_b,
    input  wire logic        i_teach_done,
    input  wire logic        i_teach_ok,
    input  wire logic        i_teach_data_bad,
    input  wire logic [7:0]  i_teach_resp_ms,
    input  wire logic        i_other_line_toggle,
    output logic             o_safety_switch_output,
    output logic             o_locked,
    output logic [7:0]       o_fault_code,
    output logic [7:0]       o_warning_code,
    output logic             o_warning_pulse
);
    initial begin
        if (MS_CYCLES < 1 || MS_CYCLES > 65535 || IDLE_TIMEOUT_MS > 32'h00ff_ffff)
            $error("gfs_supervisor: unsupported timing parameters");
    end

    // ----------------------------------------
    // Millisecond tick
    // ----------------------------------------
    logic [15:0] ms_div;
    logic        ms_tick;

    always_ff @(posedge i_clk) begin
        if (i_reset || ms_div == 16'(MS_CYCLES - 1)) begin
            ms_div  <= 16'h0000;
        end else begin
            ms_div  <= ms_div + 16'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        ms_tick <= !i_reset && ms_div == 16'(MS_CYCLES - 1);
    end

    function automatic logic [23:0] sat_inc(input logic [23:0] v);
        sat_inc = (v == 24'hff_ffff) ? v : v + 24'h00_0001;
    endfunction

    // ----------------------------------------
    // Input history
    // ----------------------------------------
    logic       cs_d;
    logic       th_d;
    logic       res_d;
    logic [2:0] mode_start;
    logic       cs_rise;
    logic       cs_fall;
    logic       res_edge;
    logic       m16;
    logic       m45;

    assign cs_rise  = i_gating_control && !cs_d;
    assign cs_fall  = !i_gating_control && cs_d;
    assign res_edge = i_restart_button_input != res_d;
    assign m16      = i_mode == `GFS_MODE_1 || i_mode == `GFS_MODE_6;
    assign m45      = i_mode == `GFS_MODE_4 || i_mode == `GFS_MODE_5;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cs_d  <= 1'b0;
            th_d  <= 1'b0;
            res_d <= 1'b0;
        end else begin
            cs_d  <= i_gating_control;
            th_d  <= i_transport_hold_input;
            res_d <= i_restart_button_input;
        end
    end

    // ----------------------------------------
    // Timers (milliseconds)
    // ----------------------------------------
    gfs_pkg::gfs_state_e state;
    logic [23:0] t_seq;
    logic [23:0] t_end;
    logic [23:0] t_skew;
    logic [23:0] t_free;
    logic [23:0] t_key;
    logic [23:0] t_teach;
    logic        broke;
    logic        th_cs_mismatch;

    assign th_cs_mismatch = (i_gating_control != th_d) || (i_transport_hold_input != cs_d);

    always_ff @(posedge i_clk) begin
        if (i_reset || cs_rise) begin
            t_seq <= 24'h00_0000;
        end else if (ms_tick) begin
            t_seq <= sat_inc(t_seq);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || i_sequence_end) begin
            t_end <= 24'h00_0000;
        end else if (ms_tick && state == gfs_pkg::GFS_ST_POST) begin
            t_end <= sat_inc(t_end);
        end
    end

    // Skew counts while the two inputs lose antivalence, so they must move together
    always_ff @(posedge i_clk) begin
        if (i_reset || i_gating_control != i_transport_hold_input) begin
            t_skew <= 24'h00_0000;
        end else if (ms_tick) begin
            t_skew <= sat_inc(t_skew);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || i_field_interrupted || state != gfs_pkg::GFS_ST_GATING) begin
            t_free <= 24'h00_0000;
        end else if (ms_tick) begin
            t_free <= sat_inc(t_free);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || i_teach_key_a == i_teach_key_b) begin
            t_key <= 24'h00_0000;
        end else if (ms_tick) begin
            t_key <= sat_inc(t_key);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || !i_teach_active) begin
            t_teach <= 24'h00_0000;
        end else if (ms_tick) begin
            t_teach <= sat_inc(t_teach);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || cs_rise) begin
            broke <= 1'b0;
        end else if (i_field_interrupted) begin
            broke <= 1'b1;
        end
    end

    // ----------------------------------------
    // Event decode
    // ----------------------------------------
    logic [7:0] fault_ev;
    logic [7:0] warn_ev;
    logic       go_off;
    logic [23:0] wait_ms;

    assign wait_ms = (i_mode == `GFS_MODE_4) ? 24'(FIELD_WAIT4_MS) : 24'(FIELD_WAIT_MS);

    always_comb begin
        fault_ev = `GFS_FAULT_NONE;
        if (i_channel_error) begin
            fault_ev = `GFS_FAULT_CHANNEL;
        end else if (state == gfs_pkg::GFS_ST_POST && i_gating_control
                     && t_end >= 24'(END_HOLD_MS)) begin
            fault_ev = `GFS_FAULT_END_HOLD;
        end else if (state == gfs_pkg::GFS_ST_GATING && cs_fall
                     && i_mode == `GFS_MODE_5 && t_seq < 24'(MIN_HOLD_MS)) begin
            fault_ev = `GFS_FAULT_MIN_HOLD;
        end else if (state == gfs_pkg::GFS_ST_GATING && !broke && i_gating_control
                     && t_seq >= 24'(IDLE_TIMEOUT_MS)) begin
            fault_ev = `GFS_FAULT_NO_FIELD;
        end else if (m16 && state == gfs_pkg::GFS_ST_OFF && res_edge
                     && i_gating_control == i_transport_hold_input) begin
            fault_ev = `GFS_FAULT_ANTIVAL;
        end else if (m16 && t_skew >= 24'(SKEW_MS)) begin
            fault_ev = `GFS_FAULT_SKEW;
        end else if (i_mode == `GFS_MODE_6 && i_top_beams_interrupted
                     && state != gfs_pkg::GFS_ST_OFF) begin
            fault_ev = `GFS_FAULT_TOP_BEAM;
        end
    end

    always_comb begin
        warn_ev = `GFS_WARN_NONE;
        go_off  = 1'b0;
        if (res_edge && i_other_line_toggle) begin
            warn_ev = `GFS_WARN_CROSS;
        end else if (i_teach_active && t_key > 24'(TEACH_KEY_MS)) begin
            warn_ev = `GFS_WARN_TEACH_KEY;
        end else if (i_teach_active && t_teach >= 24'(TEACH_TIME_MS)) begin
            warn_ev = `GFS_WARN_TEACH_TIME;
        end else if (i_teach_done && i_teach_resp_ms > 8'(`GFS_RESP_LIMIT_MS)) begin
            warn_ev = `GFS_WARN_RESP_TIME;
        end else if (i_teach_done && !i_teach_ok) begin
            warn_ev = `GFS_WARN_TEACH_BAD;
        end else if (i_teach_data_bad) begin
            warn_ev = `GFS_WARN_TEACH_DATA;
        end else if (state == gfs_pkg::GFS_ST_OFF && res_edge && i_restart_button_input
                     && ((m16 && (!i_gating_control || i_transport_hold_input))
                         || (m45 && !i_gating_control))) begin
            warn_ev = `GFS_WARN_ACK_REFUSE;
        end else if (state == gfs_pkg::GFS_ST_GATING && !broke && i_gating_control
                     && t_seq == wait_ms) begin
            warn_ev = `GFS_WARN_LATE_FIELD;
            go_off  = 1'b1;
        end else if (state == gfs_pkg::GFS_ST_GATING && !broke && !i_gating_control
                     && t_seq >= 24'(IDLE_TIMEOUT_MS)) begin
            warn_ev = `GFS_WARN_IDLE_OFF;
            go_off  = 1'b1;
        end else if (state == gfs_pkg::GFS_ST_GATING && t_free >= 24'(FREE_LIMIT_MS)) begin
            warn_ev = `GFS_WARN_FIELD_FREE;
            go_off  = 1'b1;
        end else if (state == gfs_pkg::GFS_ST_GATING && cs_fall && !broke) begin
            warn_ev = `GFS_WARN_CS_DROP;
        end
    end

    // ----------------------------------------
    // Supervisor state
    // ----------------------------------------
    // A fault always wins over a warning raised in the same cycle.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state      <= gfs_pkg::GFS_ST_START;
            mode_start <= 3'h0;
        end else begin
            case (state)
                gfs_pkg::GFS_ST_START: begin
                    mode_start <= i_mode;
                    if (!i_mode_valid || i_restart_button_input) begin
                        state <= gfs_pkg::GFS_ST_LOCKED;
                    end else begin
                        state <= gfs_pkg::GFS_ST_OFF;
                    end
                end
                gfs_pkg::GFS_ST_LOCKED: begin
                    state <= gfs_pkg::GFS_ST_LOCKED;
                end
                default: begin
                    if (i_mode != mode_start || !i_mode_valid) begin
                        state <= gfs_pkg::GFS_ST_LOCKED;
                    end else if (fault_ev != `GFS_FAULT_NONE || go_off
                                 || i_teach_active) begin
                        state <= gfs_pkg::GFS_ST_OFF;
                    end else if (state == gfs_pkg::GFS_ST_OFF) begin
                        if (res_edge && i_restart_button_input
                            && warn_ev == `GFS_WARN_NONE && !i_teach_data_bad) begin
                            state <= gfs_pkg::GFS_ST_ON;
                        end
                    end else if (state == gfs_pkg::GFS_ST_ON && cs_rise) begin
                        state <= gfs_pkg::GFS_ST_GATING;
                    end else if (state == gfs_pkg::GFS_ST_GATING && i_sequence_end) begin
                        state <= gfs_pkg::GFS_ST_POST;
                    end else if (state == gfs_pkg::GFS_ST_POST && !i_gating_control) begin
                        state <= gfs_pkg::GFS_ST_ON;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic start_cs;

    assign start_cs = state == gfs_pkg::GFS_ST_START && i_gating_control;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_safety_switch_output <= 1'b0;
            o_locked               <= 1'b0;
        end else begin
            o_safety_switch_output <= (state == gfs_pkg::GFS_ST_ON
                                       || state == gfs_pkg::GFS_ST_GATING
                                       || state == gfs_pkg::GFS_ST_POST)
                                      && fault_ev == `GFS_FAULT_NONE && !go_off
                                      && !i_teach_active && i_mode == mode_start;
            o_locked               <= state == gfs_pkg::GFS_ST_LOCKED;
        end
    end

    // Codes stay until the next one replaces them; the channel code clears on its own
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_fault_code <= `GFS_FAULT_NONE;
        end else if (state == gfs_pkg::GFS_ST_LOCKED) begin
            o_fault_code <= `GFS_FAULT_MODE;
        end else if (fault_ev != `GFS_FAULT_NONE) begin
            o_fault_code <= fault_ev;
        end else if (o_fault_code == `GFS_FAULT_CHANNEL) begin
            o_fault_code <= `GFS_FAULT_NONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_warning_code  <= `GFS_WARN_NONE;
            o_warning_pulse <= 1'b0;
        end else if (start_cs) begin
            o_warning_code  <= `GFS_WARN_START_CS;
            o_warning_pulse <= 1'b1;
        end else begin
            o_warning_pulse <= warn_ev != `GFS_WARN_NONE && state != gfs_pkg::GFS_ST_LOCKED;
            if (warn_ev != `GFS_WARN_NONE && state != gfs_pkg::GFS_ST_LOCKED) begin
                o_warning_code <= warn_ev;
            end
        end
    end
endmodule

// *** gfs_props.sv ***
// Concurrent checks on the gating fault supervisor ports
`timescale 1ns/1ps
`include "gfs_consts.svh"
module gfs_props #(
    parameter int unsigned MS_CYCLES = 2,
    parameter int unsigned SKEW_MS   = 5
) (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic [2:0] i_mode,
    input wire logic       i_mode_valid,
    input wire logic       i_gating_control,
    input wire logic       i_transport_hold_input,
    input wire logic       i_restart_button_input,
    input wire logic       i_channel_error,
    input wire logic       i_teach_active,
    input wire logic       i_teach_done,
    input wire logic       i_teach_ok,
    input wire logic [7:0] i_teach_resp_ms,
    input wire logic       o_safety_switch_output,
    input wire logic       o_locked,
    input wire logic [7:0] o_fault_code,
    input wire logic [7:0] o_warning_code
);
    // ----------------------------------------
    // Skew counter
    // ----------------------------------------
    // Slack of two ticks covers the phase of the 1 ms tick
    int unsigned skew_cnt;
    logic        mode16;
    logic        mode45;
    assign mode16 = (i_mode == `GFS_MODE_1) || (i_mode == `GFS_MODE_6);
    assign mode45 = (i_mode == `GFS_MODE_4) || (i_mode == `GFS_MODE_5);
    always_ff @(posedge i_clk) begin
        if (i_reset || !mode16 || (i_gating_control != i_transport_hold_input)) begin
            skew_cnt <= 0;
        end else if (skew_cnt < 1000) begin
            skew_cnt <= skew_cnt + 1;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_lock_forces_off: assert property (o_locked |-> !o_safety_switch_output)
        else $error("Outputs on while locked");
    a_lock_holds_codes: assert property (o_locked && $past(o_locked) |=>
        o_locked && $stable(o_fault_code) && $stable(o_warning_code))
        else $error("Locked state changed");
    a_mode_change_lock: assert property ($changed(i_mode) && !$past(i_reset)
        |-> ##[1:3] o_locked) else $error("Mode change did not lock");
    a_invalid_mode_lock: assert property (!i_mode_valid |-> ##[1:3] o_locked)
        else $error("Invalid mode did not lock");
    a_start_cs_warn: assert property ($fell(i_reset) && i_gating_control && i_mode_valid
        && !i_restart_button_input |-> ##[1:3] o_warning_code == `GFS_WARN_START_CS)
        else $error("No start-up control warning");
    a_channel_fault: assert property ($rose(i_channel_error) && !o_locked
        |-> ##[1:2] o_fault_code == `GFS_FAULT_CHANNEL) else $error("No channel fault");
    a_teach_off: assert property (i_teach_active |=> !o_safety_switch_output)
        else $error("Outputs on during teach");
    a_resp_too_long: assert property (i_teach_done && i_teach_ok && !o_locked
        && (i_teach_resp_ms > 8'h63) |=> o_warning_code == `GFS_WARN_RESP_TIME)
        else $error("Long response time accepted");
    a_ack_refused: assert property ($rose(i_restart_button_input) && mode45
        && !i_gating_control && !o_safety_switch_output |=> !o_safety_switch_output [*2])
        else $error("Acknowledge accepted without control");
    a_skew_off: assert property (skew_cnt > (SKEW_MS + 2) * MS_CYCLES + 4
        |-> !o_safety_switch_output) else $error("Outputs on under skew");
    c_locked: cover property ($rose(o_locked));
    c_outputs_on: cover property ($rose(o_safety_switch_output));
    c_teach_timeout: cover property (o_warning_code == `GFS_WARN_TEACH_TIME);
endmodule

bind gfs_supervisor gfs_props #(.MS_CYCLES(MS_CYCLES), .SKEW_MS(SKEW_MS)) u_props (.*);

// *** gfs_ctrl_model.sv ***
// Machine controller model driving gating control, transport hold and restart
`timescale 1ns/1ps
module gfs_ctrl_model (
    input  wire logic i_clk,
    output logic      o_gating_control,
    output logic      o_transport_hold_input,
    output logic      o_restart_button_input
);
    initial begin
        o_gating_control       = 1'b0;
        o_transport_hold_input = 1'b0;
        o_restart_button_input = 1'b0;
    end
    // Both lines move in one step; skew only when a caller splits the change
    task automatic drive(input logic cs, input logic th);
        o_gating_control       = cs;
        o_transport_hold_input = th;
    endtask
    task automatic hold(input logic res);
        o_restart_button_input = res;
    endtask
endmodule

// *** tb_gating_fault_supervisor.sv ***
// Self-checking testbench for the gating fault supervisor
`timescale 1ns/1ps
`include "gfs_consts.svh"
module tb_gating_fault_supervisor;
    // Timers shortened so the whole run stays a few hundred cycles
    localparam int unsigned MSC = 2;
    localparam int unsigned SKEW = 5;
    logic       i_clk;
    logic       i_reset;
    logic [2:0] i_mode;
    logic       i_mode_valid;
    logic       i_gating_control;
    logic       i_transport_hold_input;
    logic       i_restart_button_input;
    logic       i_field_interrupted;
    logic       i_top_beams_interrupted;
    logic       i_sequence_end;
    logic       i_channel_error;
    logic       i_teach_active;
    logic       i_teach_key_a;
    logic       i_teach_key_b;
    logic       i_teach_done;
    logic       i_teach_ok;
    logic       i_teach_data_bad;
    logic [7:0] i_teach_resp_ms;
    logic       i_other_line_toggle;
    logic       o_safety_switch_output;
    logic       o_locked;
    logic [7:0] o_fault_code;
    logic [7:0] o_warning_code;
    logic       o_warning_pulse;
    int         bad_count;
    int         compares;

    gfs_supervisor #(.MS_CYCLES(MSC), .END_HOLD_MS(20), .MIN_HOLD_MS(10), .FIELD_WAIT_MS(10),
        .FIELD_WAIT4_MS(5), .IDLE_TIMEOUT_MS(40), .TEACH_KEY_MS(10), .TEACH_TIME_MS(50),
        .SKEW_MS(SKEW), .FREE_LIMIT_MS(30)) dut (.*);
    gfs_ctrl_model u_ctrl (.i_clk(i_clk), .o_gating_control(i_gating_control),
        .o_transport_hold_input(i_transport_hold_input),
        .o_restart_button_input(i_restart_button_input));

    initial i_clk = 1'b0;
    always #12.5 i_clk = ~i_clk;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_code(input bit warn, input logic [7:0] exp, input int limit);
        for (int i = 0; i < limit; i++) begin
            if ((warn ? o_warning_code : o_fault_code) === exp) break;
            tick(1);
        end
        chk(warn ? o_warning_code : o_fault_code, exp);
    endtask
    task automatic start(input logic [2:0] mode, input logic cs, input logic res);
        i_mode = mode;
        i_mode_valid = 1'b1;
        {i_field_interrupted, i_channel_error, i_teach_active, i_teach_done} = 4'h0;
        {i_teach_key_a, i_teach_key_b, i_teach_ok, i_teach_data_bad} = 4'h0;
        i_teach_resp_ms = 8'h00;
        i_other_line_toggle = 1'b0;
        u_ctrl.drive(cs, 1'b0);
        u_ctrl.hold(res);
        i_reset = 1'b1;
        tick(2);
        i_reset = 1'b0;
        tick(2);
    endtask
    task automatic press();
        u_ctrl.hold(1'b1);
        tick(2);
        u_ctrl.hold(1'b0);
        tick(1);
    endtask
    task automatic summarize();
        if (bad_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_refuse();
        start(`GFS_MODE_5, 1'b0, 1'b0);
        press();
        wait_code(1'b1, `GFS_WARN_ACK_REFUSE, 8);
        chk({7'h00, o_safety_switch_output}, 8'h00);
    endtask
    task automatic t_min_hold();
        start(`GFS_MODE_5, 1'b0, 1'b0);
        u_ctrl.drive(1'b1, 1'b0);
        tick(2);
        press();
        chk({7'h00, o_safety_switch_output}, 8'h01);
        u_ctrl.drive(1'b0, 1'b0);
        tick(4);
        u_ctrl.drive(1'b1, 1'b0);
        i_field_interrupted = 1'b1;
        tick(4);
        u_ctrl.drive(1'b0, 1'b0);
        wait_code(1'b0, `GFS_FAULT_MIN_HOLD, 10);
        chk({7'h00, o_safety_switch_output}, 8'h00);
    endtask
    task automatic t_lock();
        start(`GFS_MODE_4, 1'b0, 1'b0);
        i_mode = `GFS_MODE_5;
        wait_code(1'b0, `GFS_FAULT_MODE, 5);
        i_mode = `GFS_MODE_4;
        u_ctrl.drive(1'b1, 1'b0);
        press();
        tick(3);
        chk({7'h00, o_locked}, 8'h01);
        chk({7'h00, o_safety_switch_output}, 8'h00);
        start(`GFS_MODE_4, 1'b0, 1'b1);
        tick(2);
        chk({7'h00, o_locked}, 8'h01);
    endtask
    task automatic t_channel();
        start(`GFS_MODE_5, 1'b0, 1'b0);
        i_channel_error = 1'b1;
        wait_code(1'b0, `GFS_FAULT_CHANNEL, 4);
        tick(3);
        i_channel_error = 1'b0;
        tick(3);
        chk(o_fault_code, `GFS_FAULT_NONE);
        chk({7'h00, o_locked}, 8'h00);
    endtask
    task automatic t_teach(input int kind, input logic [7:0] exp);
        start(`GFS_MODE_5, 1'b0, 1'b0);
        i_teach_active = 1'b1;
        i_teach_ok = (kind != 0);
        i_teach_resp_ms = (kind == 1) ? 8'h64 : 8'h0a;
        i_teach_data_bad = (kind == 2);
        i_teach_key_a = (kind == 3);
        i_teach_done = (kind < 2);
        tick(1);
        i_teach_done = 1'b0;
        wait_code(1'b1, exp, 130);
        chk({7'h00, o_safety_switch_output}, 8'h00);
    endtask
    task automatic t_cross();
        start(`GFS_MODE_4, 1'b0, 1'b0);
        u_ctrl.drive(1'b1, 1'b0);
        tick(2);
        u_ctrl.hold(1'b1);
        i_other_line_toggle = 1'b1;
        tick(1);
        i_other_line_toggle = 1'b0;
        tick(1);
        u_ctrl.hold(1'b0);
        wait_code(1'b1, `GFS_WARN_CROSS, 5);
    endtask
    task automatic t_signals();
        start(`GFS_MODE_5, 1'b1, 1'b0);
        wait_code(1'b1, `GFS_WARN_START_CS, 6);
        chk({7'h00, o_safety_switch_output}, 8'h00);
        start(`GFS_MODE_1, 1'b0, 1'b0);
        u_ctrl.drive(1'b1, 1'b1);
        tick(2);
        press();
        wait_code(1'b0, `GFS_FAULT_ANTIVAL, 6);
        start(`GFS_MODE_1, 1'b0, 1'b0);
        u_ctrl.drive(1'b1, 1'b1);
        wait_code(1'b0, `GFS_FAULT_SKEW, (SKEW + 3) * MSC + 6);
    endtask
    task automatic t_gating();
        start(`GFS_MODE_6, 1'b0, 1'b0);
        u_ctrl.drive(1'b1, 1'b0);
        press();
        u_ctrl.drive(1'b0, 1'b1);
        tick(2);
        u_ctrl.drive(1'b1, 1'b0);
        i_field_interrupted = 1'b1;
        tick(2);
        i_sequence_end = 1'b1;
        tick(1);
        i_sequence_end = 1'b0;
        wait_code(1'b0, `GFS_FAULT_END_HOLD, 60);
        press();
        i_top_beams_interrupted = 1'b1;
        wait_code(1'b0, `GFS_FAULT_TOP_BEAM, 4);
        chk({7'h00, o_safety_switch_output}, 8'h00);
        i_top_beams_interrupted = 1'b0;
        i_mode_valid = 1'b0;
        wait_code(1'b0, `GFS_FAULT_MODE, 5);
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        bad_count = 0;
        compares = 0;
        i_top_beams_interrupted = 1'b0;
        i_sequence_end = 1'b0;
        start(`GFS_MODE_5, 1'b0, 1'b0);
        t_refuse();
        t_min_hold();
        t_lock();
        t_channel();
        t_teach(0, `GFS_WARN_TEACH_BAD);
        t_teach(1, `GFS_WARN_RESP_TIME);
        t_teach(2, `GFS_WARN_TEACH_DATA);
        t_teach(3, `GFS_WARN_TEACH_KEY);
        t_teach(4, `GFS_WARN_TEACH_TIME);
        t_cross();
        t_signals();
        t_gating();
        summarize();
    end
    initial begin
        #125000;
        bad_count++;
        summarize();
    end
endmodule
